// ---- pmps_consts.vh ----
// Constants for the power-mode state machine.
// Assumes a 250 MHz core clock and a 32 kHz timing tick from outside.
`ifndef PMPS_CONSTS_VH
`define PMPS_CONSTS_VH
`define PMPS_PWR_CTRL_ADDR 8'h1b
`define PMPS_STANDBY_PIN_INV_BIT 6
`define PMPS_STANDBY_PIN_DLY_HI 5
`define PMPS_STANDBY_PIN_DLY_LO 4
`define PMPS_PWR_CTRL_RST 8'h10
`define PMPS_LONG_HOLD_MS 4000
`define PMPS_TICK_HZ 32768
`define PMPS_LONG_HOLD_TICKS ((`PMPS_LONG_HOLD_MS * `PMPS_TICK_HZ) / 1000)
`define PMPS_SYNC_STAGES 3
`endif

// ---- pmps_power_fsm.v ----
// Power-mode state machine: ON, OFF, Sleep, Standby, coin cell.
// Assumes tick_32k is a one-cycle pulse at 32 kHz; register port writes are synchronous.
`timescale 1ns/10ps
`include "pmps_consts.vh"
module pmps_power_fsm #(
    parameter BUCKS = 3,
    parameter LONG_HOLD_TICKS = `PMPS_LONG_HOLD_TICKS
)(
    input wire ref_clk, // Core clock
    input wire rst_n, // Async reset, from backup cell depletion
    input wire tick_32k, // 32 kHz tick pulse
    input wire uv_rise_ok, // Supply above rising threshold
    input wire uv_fall_low, // Supply below falling threshold
    input wire en_pin, // Enable pin
    input wire standby_pin, // Standby pin
    input wire therm_shutdown, // Over-temperature indication
    input wire enable_pin_config, // Enable pin config bit
    input wire long_press_off_en, // Long-hold off enable
    input wire auto_restart_en, // Auto restart enable
    input wire [BUCKS-1:0] sleep_buck_mode, // Per-buck sleep mode
    input wire [3:0] buck1_sleep_setpoint, // Buck1 sleep set point
    input wire [2:0] buck_sleep_setpoint, // Other buck sleep set point
    input wire fault_irq, // Unmasked fault pending
    input wire reg_wr, // Register write strobe
    input wire [7:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    output reg [7:0] reg_rdata, // Register read data
    output wire power_good_reset_n_o, // Reset pin output value
    output wire power_good_reset_n_oe, // Reset pin drive enable
    output wire irq_out_n_o, // Interrupt pin output value
    output wire irq_out_n_oe, // Interrupt pin drive enable
    output reg [4:0] state_onehot, // Current state
    output reg [BUCKS-1:0] buck_on, // Buck enabled
    output reg [BUCKS-1:0] buck_pfm, // Buck in PFM
    output reg [3:0] buck1_setpoint_sel, // Buck1 applied set point
    output reg [2:0] buck_setpoint_sel, // Other bucks applied set point
    output reg use_sleep_setpoint // Sleep set points active
);
    localparam S_OFF = 5'b00001;
    localparam S_ON = 5'b00010;
    localparam S_SLEEP = 5'b00100;
    localparam S_STANDBY_PIN = 5'b01000;
    localparam S_COIN = 5'b10000;

    // ************************************
    // Decode helpers
    // ************************************
    // Regulators and the interrupt pin are alive only in these states
    function is_active;
        input [4:0] s;
    begin
        is_active = (s == S_ON) || (s == S_STANDBY_PIN) || (s == S_SLEEP);
    end
    endfunction

    // Only the power control byte is mapped; every other address reads zero
    function is_pwr_ctrl;
        input [7:0] a;
    begin
        is_pwr_ctrl = (a == `PMPS_PWR_CTRL_ADDR);
    end
    endfunction

    // ************************************
    // Register and pin synchronisers
    // ************************************
    reg [7:0] pwr_ctrl_reg;
    reg [`PMPS_SYNC_STAGES-1:0] en_sync_reg;
    reg [`PMPS_SYNC_STAGES-1:0] standby_pin_sync_reg;
    reg [1:0] standby_pin_dly_reg;
    reg standby_pin_ctl_reg;
    reg [22:0] low_cnt_reg;
    reg long_low_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    // Remembers an enable power-off that must come back by itself
    reg restart_reg;
    reg restart_next;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr_ctrl_reg <= `PMPS_PWR_CTRL_RST;
        else if (reg_wr && is_pwr_ctrl(reg_addr))
            pwr_ctrl_reg <= reg_wdata;
    end

    always @*
    begin
        if (is_pwr_ctrl(reg_addr))
            reg_rdata = pwr_ctrl_reg;
        else
            reg_rdata = 8'h00;
    end

    // Whole byte is kept; only bits 6:4 steer logic here
    wire standby_pin_inv = pwr_ctrl_reg[`PMPS_STANDBY_PIN_INV_BIT];
    wire [1:0] standby_pin_dly_sel = pwr_ctrl_reg[`PMPS_STANDBY_PIN_DLY_HI:`PMPS_STANDBY_PIN_DLY_LO];

    // Three tick stages: first stage feeds only the next one
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_sync_reg <= {`PMPS_SYNC_STAGES{1'b0}};
            standby_pin_sync_reg <= {`PMPS_SYNC_STAGES{1'b0}};
        end
        else if (tick_32k)
        begin
            en_sync_reg <= {en_sync_reg[`PMPS_SYNC_STAGES-2:0], en_pin};
            standby_pin_sync_reg <= {standby_pin_sync_reg[`PMPS_SYNC_STAGES-2:0], standby_pin};
        end
    end

    wire en_s = en_sync_reg[`PMPS_SYNC_STAGES-1];
    wire standby_pin_raw = standby_pin_sync_reg[`PMPS_SYNC_STAGES-1] ^ standby_pin_inv;

    // ************************************
    // Standby delay and enable-low timer
    // ************************************
    // Decoded control follows the raw level only after the programmed hold-off
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_pin_dly_reg <= 2'h0;
            standby_pin_ctl_reg <= 1'b0;
        end
        else if (standby_pin_raw == standby_pin_ctl_reg)
            standby_pin_dly_reg <= 2'h0;
        else if (standby_pin_dly_reg >= standby_pin_dly_sel)
            standby_pin_ctl_reg <= standby_pin_raw;
        else if (tick_32k)
            standby_pin_dly_reg <= standby_pin_dly_reg + 2'h1;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt_reg <= 23'h0;
            long_low_reg <= 1'b0;
        end
        // Cleared in OFF too, so an auto restart needs a fresh long hold
        else if (en_s || (state_reg == S_OFF))
        begin
            low_cnt_reg <= 23'h0;
            long_low_reg <= 1'b0;
        end
        else if (tick_32k && !long_low_reg)
        begin
            // Longer than the hold time, so one tick past the count
            if (low_cnt_reg >= LONG_HOLD_TICKS[22:0])
                long_low_reg <= 1'b1;
            low_cnt_reg <= low_cnt_reg + 23'h1;
        end
    end

    // ************************************
    // State machine
    // ************************************
    wire any_sleep = |sleep_buck_mode;
    wire en_off = enable_pin_config ? (long_low_reg && long_press_off_en) : !en_s;
    wire turn_on = uv_rise_ok && en_s && !therm_shutdown && !restart_reg;

    // Supply loss outranks everything; thermal outranks the pins
    always @*
    begin
        state_next = state_reg;
        restart_next = restart_reg;
        case (state_reg)
            S_OFF:
            begin
                if (uv_fall_low)
                    state_next = S_COIN;
                else if (restart_reg && uv_rise_ok && !therm_shutdown)
                begin
                    state_next = S_ON;
                    restart_next = 1'b0;
                end
                else if (turn_on)
                    state_next = S_ON;
            end
            S_ON, S_STANDBY_PIN, S_SLEEP:
            begin
                if (uv_fall_low)
                    state_next = S_COIN;
                else if (therm_shutdown)
                    state_next = S_OFF;
                else if (state_reg == S_SLEEP)
                begin
                    if (en_s)
                        state_next = S_ON;
                    else if (en_off && enable_pin_config)
                        state_next = S_OFF;
                end
                else if (en_off)
                begin
                    if (any_sleep)
                        state_next = S_SLEEP;
                    else
                    begin
                        state_next = S_OFF;
                        restart_next = auto_restart_en;
                    end
                end
                else if (state_reg == S_ON && standby_pin_ctl_reg)
                    state_next = S_STANDBY_PIN;
                else if (state_reg == S_STANDBY_PIN && !standby_pin_ctl_reg)
                    state_next = S_ON;
            end
            S_COIN:
            begin
                if (uv_rise_ok)
                    state_next = S_OFF;
            end
            default:
                state_next = S_OFF;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= S_OFF;
            restart_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            restart_reg <= restart_next;
        end
    end

    // ************************************
    // Per-buck sleep handling
    // ************************************
    wire in_sleep_next = (state_next == S_SLEEP);
    wire run_next = is_active(state_next) && !in_sleep_next;
    wire [BUCKS-1:0] buck_on_next;
    wire [BUCKS-1:0] buck_pfm_next;
    genvar b;

    // In Sleep each buck follows its own mode bit: off at 0, PFM at 1
    generate
        for (b = 0; b < BUCKS; b = b + 1)
        begin : g_buck
            assign buck_on_next[b] = in_sleep_next ? sleep_buck_mode[b] : run_next;
            assign buck_pfm_next[b] = in_sleep_next && sleep_buck_mode[b];
        end
    endgenerate

    // ************************************
    // Outputs
    // ************************************
    wire pins_active = is_active(state_reg);
    // Reset pin released only in ON; low everywhere else
    assign power_good_reset_n_o = 1'b0;
    assign power_good_reset_n_oe = (state_reg != S_ON);
    assign irq_out_n_o = 1'b0;
    assign irq_out_n_oe = pins_active && fault_irq;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_onehot <= S_OFF;
            buck_on <= {BUCKS{1'b0}};
            buck_pfm <= {BUCKS{1'b0}};
            buck1_setpoint_sel <= 4'h0;
            buck_setpoint_sel <= 3'h0;
            use_sleep_setpoint <= 1'b0;
        end
        else
        begin
            state_onehot <= state_next;
            use_sleep_setpoint <= in_sleep_next;
            // Set points pass straight through; use_sleep_setpoint says when they apply
            buck1_setpoint_sel <= buck1_sleep_setpoint;
            buck_setpoint_sel <= buck_sleep_setpoint;
            buck_on <= buck_on_next;
            buck_pfm <= buck_pfm_next;
        end
    end
endmodule

// ---- pmps_power_fsm_assertions.sv ----
// Port checker for the power-mode state machine.
// Assumes binding onto pmps_power_fsm and its one-hot state codes.
`timescale 1ns/10ps
module pmps_chk (
    input wire ref_clk, // Core clock
    input wire rst_n, // Async reset, active low
    input wire uv_rise_ok, // Supply good
    input wire uv_fall_low, // Supply lost
    input wire therm_shutdown, // Over-temperature
    input wire fault_irq, // Fault pending
    input wire reg_wr, // Write strobe
    input wire [7:0] reg_addr, // Address
    input wire [7:0] reg_wdata, // Write data
    input wire [7:0] reg_rdata, // Read data
    input wire power_good_reset_n_oe, // Reset pin drive
    input wire irq_out_n_oe, // Interrupt pin drive
    input wire [4:0] state_onehot, // State
    input wire use_sleep_setpoint // Sleep set points on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    pin_reset_a: assert property (power_good_reset_n_oe == (state_onehot != 5'h02))
        else $error("reset pin drive does not match state");
    irq_gate_a: assert property (irq_out_n_oe == (fault_irq && |(state_onehot & 5'h0e)))
        else $error("interrupt drive outside active states");
    power_up_a: assert property ($past(state_onehot) == 5'h01 && state_onehot == 5'h02 |-> $past(uv_rise_ok))
        else $error("entered ON without supply good");
    coin_entry_a: assert property (state_onehot == 5'h02 && uv_fall_low |-> ##[1:40] state_onehot == 5'h10)
        else $error("supply loss in ON did not reach coin cell");
    coin_hold_a: assert property (state_onehot == 5'h10 && !uv_rise_ok |=> state_onehot == 5'h10)
        else $error("coin cell left without supply good");
    therm_hold_a: assert property (state_onehot == 5'h01 && therm_shutdown && !uv_fall_low |=> $stable(state_onehot))
        else $error("left OFF during thermal shutdown");
    reg_write_a: assert property (reg_wr && reg_addr == 8'h1b ##1 reg_addr == 8'h1b
        |-> (reg_rdata & 8'h70) == ($past(reg_wdata) & 8'h70))
        else $error("control fields not stored");
    unmapped_a: assert property (reg_addr != 8'h1b |-> reg_rdata == 8'h00)
        else $error("unmapped address reads nonzero");
    sleep_point_a: assert property (state_onehot == 5'h04 |-> ##[0:1] use_sleep_setpoint)
        else $error("sleep set points not used in Sleep");
endmodule
bind pmps_power_fsm pmps_chk pmps_chk_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .uv_rise_ok(uv_rise_ok),
    .uv_fall_low(uv_fall_low),
    .therm_shutdown(therm_shutdown),
    .fault_irq(fault_irq),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .power_good_reset_n_oe(power_good_reset_n_oe),
    .irq_out_n_oe(irq_out_n_oe),
    .state_onehot(state_onehot),
    .use_sleep_setpoint(use_sleep_setpoint)
);

// ---- pmps_host_model.sv ----
// Host model driving the enable and standby pins.
// Assumes the bench asks for levels; pins move after the falling edge.
`timescale 1ns/10ps
module pmps_host_model (
    input wire ref_clk, // Core clock
    input wire en_req, // Wanted enable level
    input wire standby_pin_req, // Wanted standby level
    output reg en_pin, // Enable pin
    output reg standby_pin // Standby pin
);
    initial
    begin
        en_pin = 1'h0;
        standby_pin = 1'h0;
    end
    // Push-pull host pins always carry a real level
    always @(negedge ref_clk)
    begin
        en_pin <= en_req;
        standby_pin <= standby_pin_req;
    end
endmodule

// ---- test_pmps_power_fsm.sv ----
// Bench for the power-mode state machine with a host on the pins.
// Assumes a 32 kHz tick every 8 core cycles to keep the run short.
`timescale 1ns/10ps
module test_pmps_power_fsm;
    reg ref_clk = 1'h0, rst_n = 1'h0, tick_32k = 1'h0, uv_rise_ok = 1'h0, uv_fall_low = 1'h0;
    reg therm_shutdown = 1'h0, enable_pin_config = 1'h0, long_press_off_en = 1'h0, auto_restart_en = 1'h0;
    reg fault_irq = 1'h1, reg_wr = 1'h0, en_req = 1'h0, standby_pin_req = 1'h0;
    reg [2:0] sleep_buck_mode = 3'h0, buck_sleep_setpoint = 3'h3, tcnt = 3'h0;
    reg [3:0] buck1_sleep_setpoint = 4'h5;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire en_pin, standby_pin, power_good_reset_n_o, power_good_reset_n_oe, irq_out_n_o, irq_out_n_oe;
    wire use_sleep_setpoint;
    wire [7:0] reg_rdata;
    wire [4:0] state_onehot;
    wire [2:0] buck_on, buck_pfm, buck_setpoint_sel;
    wire [3:0] buck1_setpoint_sel;
    wire pgr_pin = power_good_reset_n_oe ? power_good_reset_n_o : 1'h1; // External pull-up
    wire irq_pin = irq_out_n_oe ? irq_out_n_o : 1'h1; // External pull-up
    integer bad_count = 0, total_checks = 0, cyc = 0, d;
    pmps_power_fsm #(.LONG_HOLD_TICKS(8)) pmps_power_fsm_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .tick_32k(tick_32k), .uv_rise_ok(uv_rise_ok),
        .uv_fall_low(uv_fall_low), .en_pin(en_pin), .standby_pin(standby_pin), .therm_shutdown(therm_shutdown),
        .enable_pin_config(enable_pin_config), .long_press_off_en(long_press_off_en),
        .auto_restart_en(auto_restart_en), .sleep_buck_mode(sleep_buck_mode),
        .buck1_sleep_setpoint(buck1_sleep_setpoint), .buck_sleep_setpoint(buck_sleep_setpoint),
        .fault_irq(fault_irq), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .power_good_reset_n_o(power_good_reset_n_o),
        .power_good_reset_n_oe(power_good_reset_n_oe), .irq_out_n_o(irq_out_n_o),
        .irq_out_n_oe(irq_out_n_oe), .state_onehot(state_onehot), .buck_on(buck_on), .buck_pfm(buck_pfm),
        .buck1_setpoint_sel(buck1_setpoint_sel), .buck_setpoint_sel(buck_setpoint_sel),
        .use_sleep_setpoint(use_sleep_setpoint));
    pmps_host_model pmps_host_model_inst (.ref_clk(ref_clk), .en_req(en_req), .standby_pin_req(standby_pin_req),
        .en_pin(en_pin), .standby_pin(standby_pin));
    always #2 ref_clk = ~ref_clk;
    always @(negedge ref_clk)
    begin
        tcnt <= tcnt + 3'h1;
        tick_32k <= (tcnt == 3'h7);
        cyc = cyc + 1;
        if (cyc == 30000)
        begin
            bad_count = bad_count + 1;
            close_out;
        end
    end
    task close_out;
    begin
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    // Bounded wait for a state, then compare
    task go(input [4:0] s, input integer n);
        integer i;
    begin
        for (i = 0; i < n && state_onehot !== s; i = i + 1)
            @(negedge ref_clk);
        chk({3'h0, state_onehot}, {3'h0, s});
    end
    endtask
    task wr(input [7:0] a, input [7:0] v);
    begin
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'h1;
        @(negedge ref_clk);
        reg_wr = 1'h0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] v);
    begin
        reg_addr = a;
        #1;
        chk(reg_rdata, v);
        @(negedge ref_clk);
    end
    endtask
    task hold(input integer n);
    begin
        repeat (n) @(negedge ref_clk);
    end
    endtask
    initial
    begin
        hold(20);
        rst_n = 1'h1;
        rd(8'h20, 8'h00);
        rd(8'h1b, 8'h10);
        chk({7'h0, irq_out_n_oe}, 8'h00);
        en_req = 1'h1;
        hold(100);
        go(5'h01, 0);
        uv_rise_ok = 1'h1;
        go(5'h02, 60);
        chk({7'h0, pgr_pin}, 8'h01);
        chk({7'h0, irq_out_n_oe}, 8'h01);
        fault_irq = 1'h0;
        hold(1);
        chk({7'h0, irq_out_n_oe}, 8'h00);
        chk({7'h0, irq_pin}, 8'h01);
        fault_irq = 1'h1;
        // A longer delay field must hold the response off longer
        for (d = 0; d < 4; d = d + 1)
        begin
            wr(8'h1b, {2'h0, d[1:0], 4'h0});
            standby_pin_req = 1'h1;
            hold((d + 1) * 8);
            go(5'h02, 0);
            go(5'h08, 40);
            standby_pin_req = 1'h0;
            go(5'h02, 80);
        end
        wr(8'h1b, 8'h50);
        go(5'h08, 80);
        standby_pin_req = 1'h1;
        go(5'h02, 80);
        sleep_buck_mode = 3'h5;
        en_req = 1'h0;
        go(5'h04, 60);
        hold(2);
        chk({5'h0, buck_pfm}, 8'h05);
        chk({5'h0, buck_on}, 8'h05);
        chk({4'h0, buck1_setpoint_sel}, 8'h05);
        chk({5'h0, buck_setpoint_sel}, 8'h03);
        chk({7'h0, use_sleep_setpoint}, 8'h01);
        chk({7'h0, irq_pin}, 8'h00);
        chk({7'h0, irq_out_n_oe}, 8'h01);
        en_req = 1'h1;
        go(5'h02, 60);
        chk({7'h0, use_sleep_setpoint}, 8'h00);
        sleep_buck_mode = 3'h0;
        enable_pin_config = 1'h1;
        long_press_off_en = 1'h1;
        en_req = 1'h0;
        hold(56);
        go(5'h02, 0);
        go(5'h01, 120);
        enable_pin_config = 1'h0;
        en_req = 1'h1;
        go(5'h02, 60);
        enable_pin_config = 1'h1;
        auto_restart_en = 1'h1;
        en_req = 1'h0;
        go(5'h01, 160);
        go(5'h02, 100);
        auto_restart_en = 1'h0;
        enable_pin_config = 1'h0;
        go(5'h01, 60);
        chk({7'h0, pgr_pin}, 8'h00);
        standby_pin_req = 1'h0;
        hold(80);
        go(5'h01, 0);
        en_req = 1'h1;
        go(5'h02, 60);
        therm_shutdown = 1'h1;
        go(5'h01, 60);
        hold(80);
        go(5'h01, 0);
        therm_shutdown = 1'h0;
        go(5'h02, 80);
        uv_rise_ok = 1'h0;
        uv_fall_low = 1'h1;
        go(5'h10, 60);
        hold(80);
        go(5'h10, 0);
        chk({7'h0, pgr_pin}, 8'h00);
        uv_rise_ok = 1'h1;
        uv_fall_low = 1'h0;
        go(5'h01, 60);
        go(5'h02, 60);
        wr(8'h1b, 8'h60);
        rst_n = 1'h0;
        hold(2);
        rst_n = 1'h1;
        rd(8'h1b, 8'h10);
        go(5'h01, 0);
        close_out;
    end
endmodule
